//--- pkg/i2cse_consts.svh
// constants of the two-wire slave engine: bit slots, codes, reset values
// assumes inclusion by bare name from the design files
`ifndef I2CSE_CONSTS_SVH
`define I2CSE_CONSTS_SVH

// bit slot counter: 8 data bits, then the acknowledge slot
`define I2CSE_BIT_ACK 4'h8
`define I2CSE_BIT_END 4'h9
`define I2CSE_CNT_RST 4'h0

// address codes
`define I2CSE_TEN_HDR 5'h1e
`define I2CSE_GC_ADDR 8'h00

// transmit fifo shape
`define I2CSE_FIFO_WIDTH 8
`define I2CSE_FIFO_DEPTH 32

// reset values
`define I2CSE_REL_RST 1'b1
`define I2CSE_BYTE_RST 8'h00

`endif

//--- pkg/i2cse_pkg.sv
// types shared by the two-wire slave engine
// assumes nothing beyond a SystemVerilog compiler
package i2cse_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr2,
    st_rx,
    st_tx,
    st_wait
  } i2cse_state_t;

  typedef struct packed {
    logic module_enable;
    logic ten_bit_addr_select;
    logic rx_stretch_enable;
    logic accept_all_enable;
    logic general_call_enable;
  } i2cse_cfg_t;

  typedef struct packed {
    logic slave_event_flag;
    logic master_event_flag;
  } i2cse_evt_t;

endpackage

//--- design/i2cse_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "i2cse_consts.svh"

module i2cse_fifo #(
  parameter int WIDTH = `I2CSE_FIFO_WIDTH,
  parameter int DEPTH = `I2CSE_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) next_count = count + 1'b1;
    else if (pop && !push) next_count = count - 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      in_ready <= next_count != FULL;
      out_valid <= next_count != '0;
    end
  end
endmodule // i2cse_fifo

`default_nettype wire

//--- design/i2cse_slave.sv
// slave engine of a two-wire serial bus: addressing, byte moves, stretching
// assumes pins sampled on core_clk (10 MHz); open-drain wire resolved outside
//
// Behaviour
// [RL1] 7-bit: bits 7..1 match address, bit0 direction
// [RL2] sample every bit on rising bus clock
// [RL3] address match: acknowledge, slave event, buffer untouched
// [RL4] read direction: ack, hold clock, shift byte out
// [RL5] transmit: slave event each ninth fall always
// [RL6] receive: load buffer if empty, ack unless overflow
// [RL7] buffer full: no ack, no load, still event
// [RL8] overflow set, buffer empty: load, no ack
// [RL9] 10-bit header byte match, clears full match
// [RL10] second byte matches low bits, sets full match
// [RL11] master rereads 10-bit slave via repeated start
// [RL12] transmit always stretches when buffer empty after ack
// [RL13] software may set release at any time
// [RL14] receive stretch on ninth fall if buffer full
// [RL15] 10-bit address phase stretches when enabled
// [RL16] release clear grabs clock only while low
// [RL17] stretch disabled: software clear of release ignored
// [RL18] separate slave and master event flags
// [RL19] accept-all enable skips address compare
// [RL20] general call recognised only when enabled
// [RL21] general call: load buffer, master event
// [RL22] idle waits for start only when enabled
// [RL23] ten-bit address register with width select
// [RL24] stop abandons transfer, returns to idle
`timescale 1ns/1ps
`default_nettype none
`include "i2cse_consts.svh"

module i2cse_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // configuration
  input wire i2cse_pkg::i2cse_cfg_t cfg,
  input wire logic [9:0] slave_address_reg,
  // transmit data
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] tx_register,
  output logic tx_buffer_full,
  // receive data
  output logic [7:0] rx_buffer,
  output logic rx_buffer_full,
  input wire logic rx_read,
  output logic rx_overflow_flag,
  input wire logic ovf_clear,
  // clock release
  output logic clock_release,
  input wire logic rel_set,
  input wire logic rel_clear,
  // status and events
  output logic full_match_flag,
  output i2cse_pkg::i2cse_evt_t evt
);

  function automatic logic own7_hit(input logic [7:0] sh, input logic [9:0] a);
    return sh[7:1] == a[6:0];
  endfunction

  function automatic logic hdr10_hit(input logic [7:0] sh, input logic [9:0] a);
    return sh[7:3] == `I2CSE_TEN_HDR && sh[2:1] == a[9:8];
  endfunction

  i2cse_pkg::i2cse_state_t state;
  i2cse_pkg::i2cse_state_t pend_state;
  i2cse_pkg::i2cse_state_t d_state;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [3:0] cnt;
  logic [7:0] rx_shift_reg;
  logic m_ack;
  logic pend_slv;
  logic pend_gc;
  logic rise, fall, start_det, stop_det, go, take8, take9;
  logic gc_hit, stretch_hw;
  logic d_ack, d_slv, d_gc, d_load, d_ovf, d_fm_set, d_fm_clr;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic pop;

  // pin synchronisers, third stage for edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign rise = scl_s && !scl_d;
  assign fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign go = cfg.module_enable && !stop_det && !start_det && state != i2cse_pkg::st_idle;
  assign take8 = go && fall && cnt == `I2CSE_BIT_ACK;
  assign take9 = go && fall && cnt == `I2CSE_BIT_END;
  assign gc_hit = cfg.general_call_enable && rx_shift_reg == `I2CSE_GC_ADDR; // see [RL20]

  // decision at the fall that opens the acknowledge slot
  always_comb begin
    d_state = i2cse_pkg::st_wait;
    d_ack = 1'b0;
    d_slv = 1'b0;
    d_gc = 1'b0;
    d_load = 1'b0;
    d_ovf = 1'b0;
    d_fm_set = 1'b0;
    d_fm_clr = 1'b0;
    case (state)
      i2cse_pkg::st_addr: begin
        if (gc_hit) begin
          d_ack = 1'b1;
          d_gc = 1'b1;
          d_load = 1'b1; // see [RL21]
          d_state = i2cse_pkg::st_rx;
        end else if (!cfg.ten_bit_addr_select) begin // see [RL23]
          if (cfg.accept_all_enable || own7_hit(rx_shift_reg, slave_address_reg)) begin // see [RL19]
            d_ack = 1'b1; // see [RL3]
            d_slv = 1'b1;
            d_state = rx_shift_reg[0] ? i2cse_pkg::st_tx : i2cse_pkg::st_rx; // see [RL1]
          end
        end else if (cfg.accept_all_enable || hdr10_hit(rx_shift_reg, slave_address_reg)) begin
          if (!rx_shift_reg[0]) begin
            d_ack = 1'b1; // see [RL9]
            d_slv = 1'b1;
            d_fm_clr = 1'b1;
            d_state = i2cse_pkg::st_addr2;
          end else if (full_match_flag) begin
            d_ack = 1'b1; // see [RL11]
            d_slv = 1'b1;
            d_state = i2cse_pkg::st_tx;
          end else begin
            d_fm_clr = 1'b1;
          end
        end else begin
          d_fm_clr = 1'b1;
        end
      end
      i2cse_pkg::st_addr2: begin
        if (cfg.accept_all_enable || rx_shift_reg == slave_address_reg[7:0]) begin
          d_ack = 1'b1; // see [RL10]
          d_slv = 1'b1;
          d_fm_set = 1'b1;
          d_state = i2cse_pkg::st_rx;
        end else begin
          d_fm_clr = 1'b1;
        end
      end
      i2cse_pkg::st_rx: begin
        d_slv = 1'b1; // see [RL7]
        d_state = i2cse_pkg::st_rx;
        if (!rx_buffer_full) begin
          d_load = 1'b1; // see [RL6]
          d_ack = !rx_overflow_flag; // see [RL8]
        end else begin
          d_ovf = 1'b1;
        end
      end
      i2cse_pkg::st_tx: begin
        d_slv = 1'b1; // see [RL5]
        d_state = i2cse_pkg::st_tx;
      end
      default: begin
        d_state = i2cse_pkg::st_wait;
      end
    endcase
  end

  // bit counting, shifting, acknowledge and data drive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= i2cse_pkg::st_idle;
      pend_state <= i2cse_pkg::st_idle;
      cnt <= `I2CSE_CNT_RST;
      rx_shift_reg <= `I2CSE_BYTE_RST;
      m_ack <= 1'b0;
      pend_slv <= 1'b0;
      pend_gc <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!cfg.module_enable || stop_det) begin
      state <= i2cse_pkg::st_idle; // see [RL22] see [RL24]
      cnt <= `I2CSE_CNT_RST;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state <= i2cse_pkg::st_addr;
      cnt <= `I2CSE_CNT_RST;
      sda_oe <= 1'b0;
    end else if (state != i2cse_pkg::st_idle) begin
      if (rise && cnt != `I2CSE_BIT_END) cnt <= cnt + 4'h1;
      if (rise && cnt < `I2CSE_BIT_ACK) rx_shift_reg <= {rx_shift_reg[6:0], sda_s}; // see [RL2]
      if (rise && cnt == `I2CSE_BIT_ACK) m_ack <= !sda_s;
      if (take8) begin
        pend_state <= d_state;
        pend_slv <= d_slv;
        pend_gc <= d_gc;
        sda_oe <= d_ack;
      end else if (take9) begin
        cnt <= `I2CSE_CNT_RST;
        sda_oe <= 1'b0;
        if (state == i2cse_pkg::st_tx && !m_ack) state <= i2cse_pkg::st_wait;
        else state <= pend_state;
      end else if (state == i2cse_pkg::st_tx && cnt < `I2CSE_BIT_ACK && !scl_s) begin
        sda_oe <= !tx_register[~cnt[2:0]]; // see [RL4]
      end
    end
  end

  // receive buffer and overflow; set wins over software clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_buffer <= `I2CSE_BYTE_RST;
      rx_buffer_full <= 1'b0;
      rx_overflow_flag <= 1'b0;
    end else begin
      if (take8 && d_load) rx_buffer <= rx_shift_reg; // see [RL6]
      if (take8 && d_load) rx_buffer_full <= 1'b1;
      else if (rx_read) rx_buffer_full <= 1'b0;
      if (take8 && d_ovf) rx_overflow_flag <= 1'b1; // see [RL7]
      else if (ovf_clear) rx_overflow_flag <= 1'b0;
    end
  end

  // transmit register, fed from the fifo
  assign pop = fifo_valid && !tx_buffer_full;

  i2cse_fifo #(
    .WIDTH(`I2CSE_FIFO_WIDTH),
    .DEPTH(`I2CSE_FIFO_DEPTH)
  ) u_txq (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(!tx_buffer_full),
    .out_data(fifo_data)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_register <= `I2CSE_BYTE_RST;
      tx_buffer_full <= 1'b0;
    end else if (pop) begin
      tx_register <= fifo_data;
      tx_buffer_full <= 1'b1;
    end else if (take8 && state == i2cse_pkg::st_tx) begin
      tx_buffer_full <= 1'b0;
    end
  end

  // automatic stretch on the ninth falling edge
  assign stretch_hw = take9 && (
    (pend_state == i2cse_pkg::st_tx && state != i2cse_pkg::st_tx) ||
    (state == i2cse_pkg::st_tx && m_ack && !tx_buffer_full) ||
    (cfg.rx_stretch_enable && state == i2cse_pkg::st_rx && rx_buffer_full) ||
    (cfg.rx_stretch_enable && cfg.ten_bit_addr_select &&
     (state == i2cse_pkg::st_addr || state == i2cse_pkg::st_addr2) &&
     pend_state != i2cse_pkg::st_wait)); // see [RL12] see [RL14] see [RL15]

  // clock release and clock hold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clock_release <= `I2CSE_REL_RST;
      scl_oe <= 1'b0;
    end else begin
      if (rel_set) clock_release <= 1'b1; // see [RL13]
      else if (stretch_hw || (rel_clear && cfg.rx_stretch_enable)) clock_release <= 1'b0; // see [RL17]
      if (clock_release) scl_oe <= 1'b0;
      else if (!scl_s) scl_oe <= 1'b1; // see [RL16]
    end
  end

  // full match flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) full_match_flag <= 1'b0;
    else if (take8 && d_fm_set) full_match_flag <= 1'b1; // see [RL10]
    else if (take8 && d_fm_clr) full_match_flag <= 1'b0; // see [RL9]
  end

  // one-cycle event pulses on the ninth falling edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt <= '0;
    end else begin
      evt.slave_event_flag <= take9 && pend_slv; // see [RL18]
      evt.master_event_flag <= take9 && pend_gc; // see [RL21]
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SAMPLE_RISE: // see [RL2]
    assert property (go && rise && cnt < `I2CSE_BIT_ACK |=> rx_shift_reg[0] == $past(sda_s))
    else $error("bit not sampled on rising clock");

  AST_ADDR_EVENT: // see [RL3]
    assert property (take9 && pend_slv |=> evt.slave_event_flag && !evt.master_event_flag)
    else $error("slave event missing at ninth fall");

  AST_ADDR_KEEPS_RX: // see [RL3]
    assert property (take8 && state == i2cse_pkg::st_addr && !gc_hit && !rx_read
      |=> rx_buffer == $past(rx_buffer) && rx_buffer_full == $past(rx_buffer_full))
    else $error("address byte disturbed receive buffer");

  AST_RX_LOAD: // see [RL6]
    assert property (take8 && state == i2cse_pkg::st_rx && !rx_buffer_full && !rx_overflow_flag
      |=> rx_buffer_full && sda_oe && rx_buffer == $past(rx_shift_reg))
    else $error("received byte not loaded and acknowledged");

  AST_RX_FULL: // see [RL7]
    assert property (take8 && state == i2cse_pkg::st_rx && rx_buffer_full
      |=> !sda_oe && rx_overflow_flag && rx_buffer == $past(rx_buffer))
    else $error("full buffer overwritten or acknowledged");

  AST_OVF_LOAD: // see [RL8]
    assert property (take8 && state == i2cse_pkg::st_rx && !rx_buffer_full && rx_overflow_flag
      |=> !sda_oe && rx_buffer_full)
    else $error("overflow case mishandled");

  AST_TX_STRETCH: // see [RL12]
    assert property (take9 && state == i2cse_pkg::st_tx && m_ack && !tx_buffer_full && !rel_set
      |=> !clock_release ##1 (scl_oe || scl_s))
    else $error("transmit did not stretch with empty buffer");

  AST_RX_STRETCH: // see [RL14]
    assert property (take9 && cfg.rx_stretch_enable && state == i2cse_pkg::st_rx
      && rx_buffer_full && !rel_set |=> !clock_release)
    else $error("receive did not stretch with full buffer");

  AST_SW_CLEAR_IGNORED: // see [RL17]
    assert property (!cfg.rx_stretch_enable && clock_release && !stretch_hw |=> clock_release)
    else $error("release cleared while stretching disabled");

  AST_HOLD_ONLY_LOW: // see [RL16]
    assert property ($rose(scl_oe) |-> $past(!scl_s) && $past(!clock_release))
    else $error("clock grabbed while high or released");

  AST_STOP_IDLE: // see [RL24]
    assert property (stop_det |=> state == i2cse_pkg::st_idle ##1 !evt.slave_event_flag)
    else $error("stop did not return to idle");

  AST_DISABLED_IDLE: // see [RL22]
    assert property (!cfg.module_enable |=> state == i2cse_pkg::st_idle && !sda_oe)
    else $error("engine active while disabled");

  AST_GC_MASTER: // see [RL21]
    assert property (take8 && state == i2cse_pkg::st_addr && gc_hit
      |=> rx_buffer_full && sda_oe ##[1:200] evt.master_event_flag)
    else $error("general call not handled");

  COV_SLAVE_TX:
    cover property (take9 && state == i2cse_pkg::st_tx && m_ack);
  COV_RX_OVERFLOW:
    cover property (take8 && d_ovf);
  COV_GENERAL_CALL:
    cover property (evt.master_event_flag);
  COV_TEN_BIT_MATCH:
    cover property (take8 && d_fm_set);
endmodule // i2cse_slave

`default_nettype wire

//--- testbench/i2cse_master_model.sv
// behavioural bus master for the slave engine bench, 800 ns bus clock
// assumes open-drain lines resolved with pull-ups in the bench
`timescale 1ns/1ps
`default_nettype none
module i2cse_master_model (
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // pull-down drives
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release clock, wait out any stretch, bounded
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 400) begin
      #100;
      n++;
    end
  endtask
  // data moves in low phase only, sampled mid-high
  task automatic clk_bit(input logic b, output logic s);
    #150 sda_low = !b;
    #250 rise();
    #200 s = sda;
    #200 scl_low = 1'b1;
  endtask
  // also serves as repeated start from the low phase
  task automatic start();
    #150 sda_low = 1'b0;
    #250 rise();
    #400 sda_low = 1'b1;
    #400 scl_low = 1'b1;
  endtask
  task automatic stop();
    #150 sda_low = 1'b1;
    #250 rise();
    #400 sda_low = 1'b0;
    #400;
  endtask
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(!mack, s);
  endtask
endmodule // i2cse_master_model
`default_nettype wire

//--- testbench/tb_top.sv
// bench for the two-wire slave engine: master model plus software pokes
// assumes i2cse_slave and i2cse_master_model compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic core_clk, rst, rx_read, ovf_clear, rel_set, rel_clear, tx_valid, ack;
  logic [7:0] tx_data, tx_register, rx_buffer, d;
  logic [9:0] slave_address_reg;
  i2cse_pkg::i2cse_cfg_t cfg;
  i2cse_pkg::i2cse_evt_t evt;
  logic scl_out, scl_oe, sda_out, sda_oe, tx_ready, tx_buffer_full, rx_buffer_full;
  logic rx_overflow_flag, clock_release, full_match_flag, m_scl_low, m_sda_low;
  wire logic scl, sda;
  int errors, checks_done, slv_n, mst_n, n, m;
  // pull-ups: a line is high unless someone pulls it
  assign scl = !(m_scl_low || (scl_oe && !scl_out));
  assign sda = !(m_sda_low || (sda_oe && !sda_out));
  i2cse_slave u_i2cse_slave (.core_clk(core_clk), .rst(rst), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .cfg(cfg), .slave_address_reg(slave_address_reg), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_register(tx_register),
    .tx_buffer_full(tx_buffer_full), .rx_buffer(rx_buffer), .rx_buffer_full(rx_buffer_full),
    .rx_read(rx_read), .rx_overflow_flag(rx_overflow_flag), .ovf_clear(ovf_clear),
    .clock_release(clock_release), .rel_set(rel_set), .rel_clear(rel_clear),
    .full_match_flag(full_match_flag), .evt(evt));
  i2cse_master_model u_master (.scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  always @(posedge core_clk) begin
    if (evt.slave_event_flag === 1'b1) slv_n++;
    if (evt.master_event_flag === 1'b1) mst_n++;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // 0 read, 1 overflow clear, 2 release set, 3 release clear
  task automatic pulse(input int k);
    @(posedge core_clk);
    case (k)
      0: rx_read <= 1'b1;
      1: ovf_clear <= 1'b1;
      2: rel_set <= 1'b1;
      default: rel_clear <= 1'b1;
    endcase
    @(posedge core_clk);
    {rx_read, ovf_clear, rel_set, rel_clear} <= 4'h0;
    tick(2);
  endtask
  task automatic wr(input logic [7:0] b, input logic ea, input string nm);
    u_master.write_byte(b, ack);
    tick(6);
    `CHK(nm, ea, ack)
  endtask
  task automatic conclude();
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {rx_read, ovf_clear, rel_set, rel_clear, tx_valid} = 5'h00;
    tx_data = 8'h00;
    cfg = i2cse_pkg::i2cse_cfg_t'(5'h10);
    slave_address_reg = 10'h05a;
    tick(2);
    rst <= 1'b0;
    tick(4);
    `CHK("reset_state", 7'h12, {scl_oe, sda_oe, clock_release, rx_buffer_full, rx_overflow_flag, tx_ready, full_match_flag})
    u_master.start();
    wr(8'hb4, 1'b1, "addr_ack");
    `CHK("addr_evt", 1, slv_n)
    `CHK("addr_no_load", 1'b0, rx_buffer_full)
    wr(8'hc3, 1'b1, "data_ack");
    `CHK("rx_load", 9'h1c3, {rx_buffer_full, rx_buffer})
    wr(8'h3c, 1'b0, "full_nack");
    `CHK("full_keep", 9'h1c3, {rx_buffer_full, rx_buffer})
    `CHK("full_evt", 3, slv_n)
    `CHK("ovf_set", 1'b1, rx_overflow_flag)
    pulse(0);
    wr(8'h77, 1'b0, "ovf_nack");
    `CHK("ovf_load", 9'h177, {rx_buffer_full, rx_buffer})
    pulse(0);
    pulse(1);
    pulse(3);
    `CHK("rel_ignored", 1'b1, clock_release)
    u_master.stop();
    u_master.start();
    wr(8'h22, 1'b0, "other_addr");
    u_master.start();
    wr(8'hb4, 1'b1, "addr_again");
    repeat (3) u_master.clk_bit(1'b1, ack);
    u_master.stop();
    wr(8'hb4, 1'b0, "after_stop");
    tick(1);
    cfg <= i2cse_pkg::i2cse_cfg_t'(5'h00);
    u_master.start();
    wr(8'hb4, 1'b0, "disabled");
    u_master.stop();
    tick(1);
    cfg <= i2cse_pkg::i2cse_cfg_t'(5'h12);
    u_master.start();
    wr(8'h22, 1'b1, "accept_all");
    u_master.stop();
    for (int g = 1; g >= 0; g--) begin
      tick(1);
      cfg <= i2cse_pkg::i2cse_cfg_t'({4'h8, g[0]});
      n = mst_n;
      m = slv_n;
      u_master.start();
      wr(8'h00, g[0], "gcall_ack");
      `CHK("gcall_evt", n + g, mst_n)
      `CHK("gcall_slv", m, slv_n)
      u_master.stop();
    end
    `CHK("gcall_load", 9'h100, {rx_buffer_full, rx_buffer})
    pulse(0);
    cfg <= i2cse_pkg::i2cse_cfg_t'(5'h18);
    slave_address_reg <= 10'h2b7;
    u_master.start();
    wr(8'hf4, 1'b1, "hdr_ack");
    wr(8'hb6, 1'b0, "low_miss");
    `CHK("miss_flag", 1'b0, full_match_flag)
    u_master.start();
    wr(8'hf4, 1'b1, "hdr_ack2");
    wr(8'hb7, 1'b1, "low_ack");
    `CHK("match_flag", 1'b1, full_match_flag)
    u_master.start();
    wr(8'hf5, 1'b1, "hdr_read");
    `CHK("tx_stretch", 2'h1, {clock_release, scl_oe})
    n = 0;
    tx_valid <= 1'b1;
    tx_data <= 8'h40;
    repeat (40) begin
      @(posedge core_clk);
      if (tx_valid && tx_ready === 1'b1) n++;
      tx_data <= 8'h40 + n[7:0];
    end
    tx_valid <= 1'b0;
    `CHK("fill_count", 33, n)
    pulse(2);
    `CHK("set_while_full", 2'h2, {clock_release, scl_oe})
    m = slv_n;
    for (int i = 0; i < 33; i++) begin
      u_master.read_byte(i < 32, d);
      `CHK("tx_byte", 8'h40 + i[7:0], d)
    end
    tick(6);
    `CHK("tx_evt", m + 33, slv_n)
    `CHK("tx_no_stretch", 2'h2, {clock_release, scl_oe})
    u_master.stop();
    tick(1);
    cfg <= i2cse_pkg::i2cse_cfg_t'(5'h14);
    slave_address_reg <= 10'h05a;
    u_master.start();
    wr(8'hb4, 1'b1, "addr_ack3");
    wr(8'ha5, 1'b1, "data_ack3");
    `CHK("rx_stretch", 2'h1, {clock_release, scl_oe})
    pulse(0);
    pulse(2);
    `CHK("rx_release", 1'b0, scl_oe)
    pulse(3);
    `CHK("sw_clear", 2'h1, {clock_release, scl_oe})
    pulse(2);
    u_master.stop();
    conclude();
  end
endmodule // tb_top
`undef CHK
`default_nettype wire
